/* File: hw/group_hold_register_update.sv */
// Group hold controller: serial control bus slave, hold registers and launch logic.
// Assumes lineBlank and frameBlank come from timing logic on clk_sys; serial pins are async.
//
// Contract
// [RULE1] The hold command sits in bits 7:4 of a write-only command register; unlisted codes do nothing.
// [RULE2] Code 0000 opens collection of writes into the chosen bank and 0001 closes it.
// [RULE3] Code 0110 applies the chosen bank's writes at the next line blanking.
// [RULE4] Code 1010 applies the chosen bank's writes at the next vertical blanking.
// [RULE5] Code 1110 applies the chosen bank's writes at once.
// [RULE6] Bits 3:0 of the command choose bank zero (0000) or bank one (0001); other values do nothing.
// [RULE7] Bank zero's buffer start is its start register's low nibble followed by four zeros; reset 0x00.
// [RULE8] Bank one's buffer start is formed the same way; its register resets to 0x04.
// [RULE9] Each bank has a read-write frame period count, resetting to 0x00.
// [RULE10] Switch control bit 2 enables automatic switching, bits 1:0 pick the second bank; reset 0x01.
// [RULE11] Switch control bit 5 is the first-bank start option, bit 4 frame-count trigger, bit 3 repeat.
// [RULE12] Test register bit 4 enables buffer SRAM test mode, bits 3:0 are read margin; reset 0x0f.
// [RULE13] Read-only registers show the active bank and a running frame count per bank.
// [RULE14] Two read-only registers show how many writes each bank holds.
// [RULE15] While a hold is open writes are stored, then applied in original order on launch.
// [RULE16] Registers are reached over the two-wire bus at write address 0xc0 and read address 0xc1.
// [RULE17] Every enable bit means enabled at 1 and disabled at 0.
`timescale 1ns/1ps
module group_hold_register_update
  import group_hold_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic lineBlank,
  input wire logic frameBlank,
  output logic applyValid,
  output logic [15:0] applyAddr,
  output logic [7:0] applyData,
  output logic holdOpen,
  output logic sramTestEn,
  output logic [3:0] sramReadMargin
);

  hold_buf_if buf_if ();

  logic [1:0] sclSync_ff;
  logic [1:0] sdaSync_ff;
  logic sclLast_ff;
  logic sdaLast_ff;
  serial_state_e state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] rxSh_ff;
  logic [7:0] txSh_ff;
  logic [1:0] byteIdx_ff;
  logic devHit_ff;
  logic readDir_ff;
  logic masterAck_ff;
  logic [15:0] regAddr_ff;
  logic busWr;
  logic [7:0] rdData;
  logic [7:0] bank0Start_ff, bank1Start_ff, period0_ff, period1_ff;
  logic [7:0] switchCtrl_ff, sramTest_ff, len0_ff, len1_ff, fcnt0_ff, fcnt1_ff;
  logic holdOpen_ff, holdBank_ff, activeBank_ff, autoDone_ff, swEnLast_ff, frameLast_ff;
  logic pend_ff, pendBank_ff;
  launch_mode_e pendMode_ff;
  logic cmdWr, cmdBank, ownAddr, bufWr, directWr, frameStart, autoReq, autoBank, fire;
  logic [3:0] cmdCode;
  logic [7:0] holdLen;

  hold_buffer u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bus(buf_if.store)
  );

  // ****************************************
  // Serial pin input
  // ****************************************
  // Two flops on each pin before any edge logic looks at it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclSync_ff <= 2'b11;
      sdaSync_ff <= 2'b11;
      sclLast_ff <= 1'b1;
      sdaLast_ff <= 1'b1;
    end
    else
    begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      sclLast_ff <= sclSync_ff[1];
      sdaLast_ff <= sdaSync_ff[1];
    end
  end

  wire sclRise = sclSync_ff[1] & ~sclLast_ff;
  wire sclFall = ~sclSync_ff[1] & sclLast_ff;
  wire busStart = sclSync_ff[1] & sclLast_ff & sdaLast_ff & ~sdaSync_ff[1];
  wire busStop = sclSync_ff[1] & sclLast_ff & ~sdaLast_ff & sdaSync_ff[1];
  wire byteDone = sclFall && (bitCnt_ff == BIT_COUNT_BYTE);

  // ****************************************
  // Serial slave sequencer
  // ****************************************
  // Start and stop override any state so a confused master can always recover
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= S_IDLE;
      bitCnt_ff <= 4'h0;
      rxSh_ff <= 8'h00;
      txSh_ff <= 8'h00;
      byteIdx_ff <= 2'd0;
      devHit_ff <= 1'b0;
      readDir_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      regAddr_ff <= 16'h0000;
    end
    else if (busStart)
    begin
      state_ff <= S_DEV;
      bitCnt_ff <= 4'h0;
    end
    else if (busStop)
    begin
      state_ff <= S_IDLE;
    end
    else
    begin
      unique case (state_ff)
        S_IDLE:
        begin
          bitCnt_ff <= 4'h0;
        end
        S_DEV, S_WR:
        begin
          if (sclRise)
          begin
            rxSh_ff <= {rxSh_ff[6:0], sdaSync_ff[1]};
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt_ff <= 4'h0;
            if (state_ff == S_DEV)
            begin
              devHit_ff <= (rxSh_ff[7:1] == DEV_ADDR7); // [RULE16]
              readDir_ff <= rxSh_ff[0];
              state_ff <= S_DEVACK;
            end
            else
            begin
              if (byteIdx_ff == 2'd0)
                regAddr_ff[15:8] <= rxSh_ff;
              else if (byteIdx_ff == 2'd1)
                regAddr_ff[7:0] <= rxSh_ff;
              else
                regAddr_ff <= regAddr_ff + 16'h0001;
              if (byteIdx_ff != 2'd2)
                byteIdx_ff <= byteIdx_ff + 2'd1;
              state_ff <= S_WRACK;
            end
          end
        end
        S_DEVACK:
        begin
          if (sclFall)
          begin
            byteIdx_ff <= 2'd0;
            if (!devHit_ff)
              state_ff <= S_IDLE;
            else if (readDir_ff)
            begin
              txSh_ff <= rdData;
              regAddr_ff <= regAddr_ff + 16'h0001;
              state_ff <= S_RD;
            end
            else
              state_ff <= S_WR;
          end
        end
        S_WRACK:
        begin
          if (sclFall)
            state_ff <= S_WR;
        end
        S_RD:
        begin
          if (sclRise)
            bitCnt_ff <= bitCnt_ff + 4'h1;
          else if (byteDone)
          begin
            bitCnt_ff <= 4'h0;
            state_ff <= S_RDACK;
          end
          else if (sclFall)
            txSh_ff <= {txSh_ff[6:0], 1'b0};
        end
        S_RDACK:
        begin
          if (sclRise)
            masterAck_ff <= ~sdaSync_ff[1];
          else if (sclFall)
          begin
            if (masterAck_ff)
            begin
              txSh_ff <= rdData;
              regAddr_ff <= regAddr_ff + 16'h0001;
              state_ff <= S_RD;
            end
            else
              state_ff <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Open drain: enable pulls low for acknowledge and for read zeros
  assign sdaOut = 1'b0;
  assign sdaOe = ((state_ff == S_DEVACK) && devHit_ff) || (state_ff == S_WRACK) ||
                 ((state_ff == S_RD) && !txSh_ff[7]);
  // The data byte is written at the clock fall ending its eighth bit, before the ack, using the address before the bump
  assign busWr = byteDone && (state_ff == S_WR) && (byteIdx_ff == 2'd2);

  // ****************************************
  // Write decode
  // ****************************************
  // Own registers always act at once so the command itself can never be held
  assign ownAddr = (regAddr_ff >= ADDR_OWN_FIRST) && (regAddr_ff <= ADDR_OWN_LAST);
  assign cmdWr = busWr && (regAddr_ff == ADDR_HOLD_CMD);
  assign cmdCode = rxSh_ff[7:4]; // [RULE1]
  assign cmdBank = (rxSh_ff[3:0] == BANK_ID1);
  wire cmdBankOk = (rxSh_ff[3:0] == BANK_ID0) || (rxSh_ff[3:0] == BANK_ID1); // [RULE6]
  assign holdLen = holdBank_ff ? len1_ff : len0_ff;
  assign bufWr = busWr && !ownAddr && holdOpen_ff && (holdLen != LEN_MAX); // [RULE15]
  assign directWr = busWr && !ownAddr && !holdOpen_ff;

  // Plain read-write configuration registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bank0Start_ff <= RST_BANK0_START; // [RULE7]
      bank1Start_ff <= RST_BANK1_START; // [RULE8]
      period0_ff <= RST_PERIOD; // [RULE9]
      period1_ff <= RST_PERIOD;
      switchCtrl_ff <= RST_SWITCH_CTRL; // [RULE10]
      sramTest_ff <= RST_SRAM_TEST; // [RULE12]
    end
    else if (busWr)
    begin
      if (regAddr_ff == ADDR_BANK0_START) bank0Start_ff <= rxSh_ff;
      if (regAddr_ff == ADDR_BANK1_START) bank1Start_ff <= rxSh_ff;
      if (regAddr_ff == ADDR_BANK0_PERIOD) period0_ff <= rxSh_ff; // [RULE9]
      if (regAddr_ff == ADDR_BANK1_PERIOD) period1_ff <= rxSh_ff;
      if (regAddr_ff == ADDR_SWITCH_CTRL) switchCtrl_ff <= rxSh_ff; // [RULE11]
      if (regAddr_ff == ADDR_SRAM_TEST) sramTest_ff <= rxSh_ff;
    end
  end

  wire [7:0] base0 = {bank0Start_ff[3:0], LOW_PAD}; // [RULE7]
  wire [7:0] base1 = {bank1Start_ff[3:0], LOW_PAD}; // [RULE8]
  assign sramTestEn = sramTest_ff[SRAM_TEST_EN]; // [RULE12] [RULE17]
  assign sramReadMargin = sramTest_ff[3:0];

  // ****************************************
  // Hold open, close and collected lengths
  // ****************************************
  // Opening a bank empties it; writes past the last entry are dropped
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      holdOpen_ff <= 1'b0;
      holdBank_ff <= 1'b0;
      len0_ff <= 8'h00;
      len1_ff <= 8'h00;
    end
    else if (cmdWr && cmdBankOk && (cmdCode == CMD_HOLD_START))
    begin
      holdOpen_ff <= 1'b1; // [RULE2]
      holdBank_ff <= cmdBank;
      if (cmdBank) len1_ff <= 8'h00;
      else len0_ff <= 8'h00;
    end
    else if (cmdWr && cmdBankOk && (cmdCode == CMD_HOLD_END) && (cmdBank == holdBank_ff))
      holdOpen_ff <= 1'b0; // [RULE2]
    else if (bufWr)
    begin
      if (holdBank_ff) len1_ff <= len1_ff + 8'h01; // [RULE14]
      else len0_ff <= len0_ff + 8'h01;
    end
  end
  assign holdOpen = holdOpen_ff;

  // ****************************************
  // Automatic switching and frame counts
  // ****************************************
  assign frameStart = frameBlank && !frameLast_ff;
  wire swEnable = switchCtrl_ff[SW_ENABLE]; // [RULE10] [RULE17]
  wire [7:0] curCnt = activeBank_ff ? fcnt1_ff : fcnt0_ff;
  wire [7:0] curPeriod = activeBank_ff ? period1_ff : period0_ff;
  wire periodDue = (curPeriod != 8'h00) && ((curCnt + 8'h01) >= curPeriod);
  // Frame-count trigger off means a switch at every frame start
  wire switchDue = switchCtrl_ff[SW_FRAME_TRIG] ? periodDue : 1'b1; // [RULE11]
  // Second bank select names bank zero's partner
  assign autoBank = activeBank_ff ? 1'b0 : switchCtrl_ff[0]; // [RULE10]
  assign autoReq = (swEnable && !swEnLast_ff && switchCtrl_ff[SW_FIRST_OPT]) ||
                   (swEnable && frameStart && !autoDone_ff && switchDue);

  // Counts run while their bank is active and restart when it takes over
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frameLast_ff <= 1'b0;
      swEnLast_ff <= 1'b0;
      autoDone_ff <= 1'b0;
      fcnt0_ff <= 8'h00;
      fcnt1_ff <= 8'h00;
    end
    else
    begin
      frameLast_ff <= frameBlank;
      swEnLast_ff <= swEnable;
      if (!swEnable)
        autoDone_ff <= 1'b0;
      else if (fire && pendBank_ff && !switchCtrl_ff[SW_REPEAT])
        autoDone_ff <= 1'b1; // [RULE11]
      if (fire && !pendBank_ff)
        fcnt0_ff <= 8'h00;
      else if (frameStart && !activeBank_ff && (fcnt0_ff != LEN_MAX))
        fcnt0_ff <= fcnt0_ff + 8'h01; // [RULE13]
      if (fire && pendBank_ff)
        fcnt1_ff <= 8'h00;
      else if (frameStart && activeBank_ff && (fcnt1_ff != LEN_MAX))
        fcnt1_ff <= fcnt1_ff + 8'h01; // [RULE13]
    end
  end

  // ****************************************
  // Launch scheduling
  // ****************************************
  // A software launch replaces any waiting one, and wins over an automatic switch
  assign fire = pend_ff && !buf_if.busy && ((pendMode_ff == LAUNCH_NOW) || // [RULE5]
                ((pendMode_ff == LAUNCH_LINE) && lineBlank) || // [RULE3]
                ((pendMode_ff == LAUNCH_VERT) && frameBlank)); // [RULE4]
  wire cmdLaunch = cmdWr && cmdBankOk && ((cmdCode == CMD_LAUNCH_LINE) ||
                   (cmdCode == CMD_LAUNCH_VERT) || (cmdCode == CMD_LAUNCH_NOW));
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_ff <= 1'b0;
      pendBank_ff <= 1'b0;
      pendMode_ff <= LAUNCH_NOW;
      activeBank_ff <= 1'b0;
    end
    else
    begin
      if (cmdLaunch)
      begin
        pend_ff <= 1'b1;
        pendBank_ff <= cmdBank;
        if (cmdCode == CMD_LAUNCH_LINE) pendMode_ff <= LAUNCH_LINE; // [RULE3]
        else if (cmdCode == CMD_LAUNCH_VERT) pendMode_ff <= LAUNCH_VERT; // [RULE4]
        else pendMode_ff <= LAUNCH_NOW; // [RULE5]
      end
      else if (autoReq && !pend_ff)
      begin
        pend_ff <= 1'b1;
        pendBank_ff <= switchCtrl_ff[SW_FIRST_OPT] && !swEnLast_ff ? 1'b0 : autoBank;
        pendMode_ff <= LAUNCH_VERT;
      end
      else if (fire)
        pend_ff <= 1'b0;
      if (fire)
        activeBank_ff <= pendBank_ff; // [RULE13]
    end
  end

  // ****************************************
  // Buffer connection and apply port
  // ****************************************
  assign buf_if.wrEn = bufWr;
  assign buf_if.wrPtr = (holdBank_ff ? base1 : base0) + holdLen;
  assign buf_if.wrAddr = regAddr_ff;
  assign buf_if.wrData = rxSh_ff;
  assign buf_if.rdStart = fire && !cmdLaunch;
  assign buf_if.rdBase = pendBank_ff ? base1 : base0;
  assign buf_if.rdLen = pendBank_ff ? len1_ff : len0_ff;
  // A direct write takes the port and holds the replay back one cycle
  assign buf_if.stall = directWr;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      applyValid <= 1'b0;
      applyAddr <= 16'h0000;
      applyData <= 8'h00;
    end
    else
    begin
      applyValid <= directWr || buf_if.outValid;
      if (directWr)
      begin
        applyAddr <= regAddr_ff;
        applyData <= rxSh_ff;
      end
      else if (buf_if.outValid)
      begin
        applyAddr <= buf_if.outAddr; // [RULE15]
        applyData <= buf_if.outData;
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // The command register is write only and reads zero, as do unmapped addresses
  always_comb
  begin
    rdData = 8'h00;
    unique case (regAddr_ff)
      ADDR_BANK0_START: rdData = bank0Start_ff;
      ADDR_BANK1_START: rdData = bank1Start_ff;
      ADDR_BANK0_LEN: rdData = len0_ff; // [RULE14]
      ADDR_BANK1_LEN: rdData = len1_ff;
      ADDR_BANK0_PERIOD: rdData = period0_ff;
      ADDR_BANK1_PERIOD: rdData = period1_ff;
      ADDR_SWITCH_CTRL: rdData = switchCtrl_ff;
      ADDR_SRAM_TEST: rdData = sramTest_ff;
      ADDR_ACTIVE_BANK: rdData = {7'h00, activeBank_ff}; // [RULE13]
      ADDR_BANK0_FCNT: rdData = fcnt0_ff;
      ADDR_BANK1_FCNT: rdData = fcnt1_ff;
      default: rdData = 8'h00;
    endcase
  end

endmodule

/* File: hw/group_hold_pkg.sv */
// Constants, register map and types for the group hold controller.
// Assumes one system clock and a two-wire serial control bus with 16-bit register addresses.
package group_hold_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_BANK0_START = 16'h3200;
  localparam logic [15:0] ADDR_BANK1_START = 16'h3201;
  localparam logic [15:0] ADDR_BANK0_LEN = 16'h3204;
  localparam logic [15:0] ADDR_BANK1_LEN = 16'h3205;
  localparam logic [15:0] ADDR_HOLD_CMD = 16'h3208;
  localparam logic [15:0] ADDR_BANK0_PERIOD = 16'h3209;
  localparam logic [15:0] ADDR_BANK1_PERIOD = 16'h320a;
  localparam logic [15:0] ADDR_SWITCH_CTRL = 16'h320b;
  localparam logic [15:0] ADDR_SRAM_TEST = 16'h320c;
  localparam logic [15:0] ADDR_ACTIVE_BANK = 16'h320d;
  localparam logic [15:0] ADDR_BANK0_FCNT = 16'h320e;
  localparam logic [15:0] ADDR_BANK1_FCNT = 16'h320f;
  // Own registers span this range; other writes go to the target register space
  localparam logic [15:0] ADDR_OWN_FIRST = 16'h3200;
  localparam logic [15:0] ADDR_OWN_LAST = 16'h320f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_BANK0_START = 8'h00;
  localparam logic [7:0] RST_BANK1_START = 8'h04;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_SWITCH_CTRL = 8'h01;
  localparam logic [7:0] RST_SRAM_TEST = 8'h0f;

  // ****************************************
  // Fields and codes
  // ****************************************
  localparam logic [6:0] DEV_ADDR7 = 7'h60; // Write address 0xc0, read address 0xc1
  localparam logic [3:0] CMD_HOLD_START = 4'h0;
  localparam logic [3:0] CMD_HOLD_END = 4'h1;
  localparam logic [3:0] CMD_LAUNCH_LINE = 4'h6;
  localparam logic [3:0] CMD_LAUNCH_VERT = 4'ha;
  localparam logic [3:0] CMD_LAUNCH_NOW = 4'he;
  localparam logic [3:0] BANK_ID0 = 4'h0;
  localparam logic [3:0] BANK_ID1 = 4'h1;
  localparam int SW_FIRST_OPT = 5;
  localparam int SW_FRAME_TRIG = 4;
  localparam int SW_REPEAT = 3;
  localparam int SW_ENABLE = 2;
  localparam int SRAM_TEST_EN = 4;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

  // ****************************************
  // Buffer geometry and types
  // ****************************************
  localparam int BUF_DEPTH = 256;
  localparam int ENTRY_W = 24;
  localparam logic [7:0] LEN_MAX = 8'hff;

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_DEVACK, S_WR, S_WRACK, S_RD, S_RDACK} serial_state_e;
  typedef enum logic [1:0] {LAUNCH_LINE, LAUNCH_VERT, LAUNCH_NOW} launch_mode_e;

endpackage

/* File: hw/hold_buf_if.sv */
// Interface between the hold controller and its write buffer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface hold_buf_if;
  logic wrEn;
  logic [7:0] wrPtr;
  logic [15:0] wrAddr;
  logic [7:0] wrData;
  logic rdStart;
  logic [7:0] rdBase;
  logic [7:0] rdLen;
  logic stall;
  logic outValid;
  logic [15:0] outAddr;
  logic [7:0] outData;
  logic busy;
  modport ctrl (
    output wrEn, wrPtr, wrAddr, wrData, rdStart, rdBase, rdLen, stall,
    input outValid, outAddr, outData, busy
  );
  modport store (
    input wrEn, wrPtr, wrAddr, wrData, rdStart, rdBase, rdLen, stall,
    output outValid, outAddr, outData, busy
  );
endinterface

/* File: hw/hold_buffer.sv */
// Buffer of held register writes, each entry a target address and data byte.
// Assumes the controller never starts a replay while one is running.
`timescale 1ns/1ps
module hold_buffer
  import group_hold_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  hold_buf_if.store bus
);

  logic [ENTRY_W-1:0] mem [BUF_DEPTH];
  logic [7:0] rdPtr_ff;
  logic [7:0] remain_ff;

  // ****************************************
  // Storage
  // ****************************************
  // Entries carry no reset; only the lengths say what is valid
  always_ff @(posedge clk_sys)
  begin
    if (bus.wrEn)
    begin
      mem[bus.wrPtr] <= {bus.wrAddr, bus.wrData}; // [RULE15]
    end
  end

  // ****************************************
  // Replay in stored order
  // ****************************************
  // Walks upward from the bank base; a stall holds the current entry
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdPtr_ff <= 8'h00;
      remain_ff <= 8'h00;
    end
    else if (bus.rdStart)
    begin
      rdPtr_ff <= bus.rdBase;
      remain_ff <= bus.rdLen;
    end
    else if ((remain_ff != 8'h00) && !bus.stall)
    begin
      rdPtr_ff <= rdPtr_ff + 8'h01; // [RULE15]
      remain_ff <= remain_ff - 8'h01;
    end
  end

  assign bus.busy = (remain_ff != 8'h00);
  assign bus.outValid = bus.busy;
  assign {bus.outAddr, bus.outData} = mem[rdPtr_ff];

endmodule

/* File: test/group_hold_assertions.sv */
// Port-level checker for the group hold controller.
// Assumes it is bound onto the top module and sees one clock domain.
`timescale 1ns/1ps
module group_hold_assertions
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic applyValid,
  input wire logic [15:0] applyAddr,
  input wire logic holdOpen,
  input wire logic sramTestEn,
  input wire logic [3:0] sramReadMargin
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // First edge after reset release
  sequence relSeq;
    $rose(rst_b);
  endsequence
  // Open drain: the pin is only ever pulled low
  a_sda_low_only: assert property (sdaOut == 1'b0)
    else $error("serial data driven high");
  // Ack and read bits may only change while the serial clock is low
  a_oe_rise_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data pull began with clock high");
  a_oe_fall_low: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("data pull ended with clock high");
  a_reset_margin: assert property (relSeq |-> sramReadMargin == 4'hf && !sramTestEn)
    else $error("test register not at reset value");
  a_reset_quiet: assert property (relSeq |-> !applyValid && !holdOpen)
    else $error("apply or hold active after reset");
  a_no_own_apply: assert property (applyValid |-> !(applyAddr inside {[16'h3200:16'h320f]}))
    else $error("own register sent to target space");
  // Register updates land only after a bus byte, so while the clock is low
  a_test_on_write: assert property ($changed({sramTestEn, sramReadMargin}) |-> !sclIn)
    else $error("test register changed outside a write");
  a_hold_on_write: assert property ($changed(holdOpen) |-> !sclIn)
    else $error("hold state changed outside a write");
endmodule
bind group_hold_register_update group_hold_assertions i_group_hold_assertions (.clk_sys, .rst_b,
  .sclIn, .sdaOut, .sdaOe, .applyValid, .applyAddr, .holdOpen, .sramTestEn, .sramReadMargin);

/* File: test/group_hold_register_update_tb_top.sv */
// Self-checking bench: bit-banged serial master, apply port monitor.
// Assumes the design package is compiled first and the checker is bound.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errCount++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module group_hold_register_update_tb_top import group_hold_pkg::*;;
  logic clk_sys = 0, rst_b = 0, sclIn = 1, sdaIn = 1, sdaM = 1, lineBlank = 0, frameBlank = 0;
  logic sdaOut, sdaOe, applyValid, holdOpen, sramTestEn;
  logic [15:0] applyAddr;
  logic [7:0] applyData, rdv, v;
  logic [3:0] sramReadMargin;
  logic [23:0] seen[$], want[$];
  logic [31:0] rng = 10964;
  logic [15:0] regA[7] = '{16'h3200, 16'h3201, 16'h3209, 16'h320a, 16'h320b, 16'h320c, 16'h320d};
  logic [7:0] regR[7] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h01, 8'h0f, 8'h00};
  int errCount = 0, compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  group_hold_register_update i_group_hold_register_update (.clk_sys, .rst_b, .sclIn, .sdaIn,
    .sdaOut, .sdaOe, .lineBlank, .frameBlank, .applyValid, .applyAddr, .applyData, .holdOpen,
    .sramTestEn, .sramReadMargin);
  // Wire level of the open-drain line, and capture of every applied write
  always @(posedge clk_sys)
  begin
    sdaIn <= sdaM & ~sdaOe;
    if (applyValid === 1'b1)
      seen.push_back({applyAddr, applyData});
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Debug bits are not assumed stored; auto switching kept off
  function automatic logic [7:0] rwMask(input int i);
    return i == 4 ? 8'h3b : (i == 5 ? 8'h1f : 8'hff);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Each half bit lasts 8 clocks, well above the minimum high and low times
  task automatic setb(input logic c, input logic d);
    @(posedge clk_sys);
    sclIn <= c;
    sdaM <= d;
    tick(7);
  endtask
  task automatic start();
    setb(0, 1);
    setb(1, 1);
    setb(1, 0);
    setb(0, 0);
  endtask
  task automatic stop();
    setb(0, 0);
    setb(1, 0);
    setb(1, 1);
  endtask
  task automatic sendb(input logic [7:0] b, input logic ak = 1);
    for (int i = 7; i >= 0; i--)
    begin
      setb(0, b[i]);
      setb(1, b[i]);
    end
    setb(0, 1);
    setb(1, 1);
    `CHK("ack", ak, sdaOe)
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    start();
    sendb({DEV_ADDR7, 1'b0});
    sendb(a[15:8]);
    sendb(a[7:0]);
    sendb(d);
    stop();
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    start();
    sendb({DEV_ADDR7, 1'b0});
    sendb(a[15:8]);
    sendb(a[7:0]);
    start();
    sendb({DEV_ADDR7, 1'b1});
    for (int i = 7; i >= 0; i--)
    begin
      setb(0, 1);
      setb(1, 1);
      rdv[i] = ~sdaOe;
    end
    setb(0, 1);
    setb(1, 1);
    stop();
    `CHK("register", e, rdv)
  endtask
  // Random write to the target register space, remembered in order
  task automatic tw();
    rng = xs(rng);
    wr({8'h35, rng[15:8]}, rng[7:0]);
    want.push_back({8'h35, rng[15:0]});
  endtask
  task automatic achk();
    tick(20);
    `CHK("count", want.size(), seen.size())
    foreach (want[i]) `CHK("entry", want[i], seen[i])
    want = {};
    seen = {};
  endtask
  task automatic give_verdict();
    if (errCount == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    tick(2);
    rst_b <= 1;
    tick(4);
    `CHK("margin", 4'hf, sramReadMargin)
    foreach (regA[i]) rchk(regA[i], regR[i]);
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      v = rng[7:0] & rwMask(i);
      wr(regA[i], v);
      rchk(regA[i], v);
    end
    `CHK("test", {v[4], v[3:0]}, {sramTestEn, sramReadMargin})
    start();
    sendb(8'h42, 0);
    stop();
    tw();
    achk();
    wr(16'h3204, 8'h5a);
    rchk(16'h3204, 8'h00);
    wr(16'h3208, 8'h00);
    `CHK("hold", 1'b1, holdOpen)
    repeat (3) tw();
    `CHK("held", 0, seen.size())
    rchk(16'h3204, 8'h03);
    wr(16'h3208, 8'h10);
    `CHK("hold", 1'b0, holdOpen)
    wr(16'h3208, 8'he0);
    achk();
    wr(16'h3208, 8'h01);
    repeat (2) tw();
    wr(16'h3208, 8'h11);
    rchk(16'h3205, 8'h02);
    wr(16'h3208, 8'h61);
    tick(20);
    `CHK("early", 0, seen.size())
    lineBlank <= 1;
    achk();
    lineBlank <= 0;
    rchk(16'h320d, 8'h01);
    wr(16'h3208, 8'h00);
    tw();
    wr(16'h3208, 8'h10);
    wr(16'h3208, 8'ha0);
    lineBlank <= 1;
    tick(20);
    lineBlank <= 0;
    `CHK("early", 0, seen.size())
    frameBlank <= 1;
    achk();
    frameBlank <= 0;
    rchk(16'h320d, 8'h00);
    // Auto switch every frame to bank one, no repeat: one switch, then it stays
    wr(16'h320b, 8'h05);
    repeat (2)
    begin
      frameBlank <= 1;
      tick(5);
      frameBlank <= 0;
      tick(20);
    end
    rchk(16'h320d, 8'h01);
    `CHK("replay", 2, seen.size())
    rchk(16'h320f, 8'h01);
    seen = {};
    wr(16'h320b, 8'h01);
    wr(16'h3208, 8'h02);
    `CHK("hold", 1'b0, holdOpen)
    wr(16'h3208, 8'h30);
    `CHK("hold", 1'b0, holdOpen)
    give_verdict();
  end
endmodule
